// ==== pkg/lin_regs.vh ====
// Register map, field positions and timing counts of the LIN slave block
`ifndef LIN_SLAVE_REGS_VH
`define LIN_SLAVE_REGS_VH

`define ADDR_STATUS       8'h40
`define ADDR_BAUD         8'h42
`define ADDR_CR3          8'h45
`define ADDR_ERPR         8'h46
`define ADDR_ETPR         8'h47

`define CR3_LIN_ENABLE    6
`define CR3_SLAVE_SELECT  5
`define CR3_AUTO_SYNCH    4
`define CR3_DETECT_METHOD 3
`define CR3_HDR_IRQ_EN    2
`define CR3_HDR_FLAG      1
`define CR3_SYNCH_STATE   0
`define STATUS_HDR_ERR    3

`define RESET_BYTE        8'h00
`define FRAC_W            4
`define FRAC_MSB          3
`define MANT_OFF          8'h00
`define LHL_AFTER_BREAK   8'hff
`define LHL_TIMEOUT       8'h00
`define LHL_MAX_QUARTERS  9'd228
`define QUARTER_ROUND     11'd2
`define TICKS_PER_BIT     16
`define BREAK_TICKS       11'd176
`define CHAR_TICKS        11'd160
`define HEADER_MAX_TICKS  11'd912
`define SYNCH_FALL_EDGES  3'd5
`define ACC_STEP          13'h0010

`endif

// ==== core/lin_frac_divider.v ====
// Fractional baud divider producing the sixteen-times oversampling tick
`timescale 1ns/1ns
`include "lin_regs.vh"
module lin_frac_divider (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [7:0] i_mantissa,
  input  wire [3:0] i_fraction,
  output reg        o_tick,
  output wire       o_clk_on
);
  // Divider in sixteenths of a clock: one tick per baud_divider clocks
  wire [12:0] target = {1'b0, i_mantissa, i_fraction};
  wire [12:0] sum;
  reg  [12:0] acc;

  assign o_clk_on = (i_mantissa != `MANT_OFF);
  assign sum      = acc + `ACC_STEP;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc    <= 13'h0000;
      o_tick <= 1'b0;
    end else if (!o_clk_on) begin
      acc    <= 13'h0000;
      o_tick <= 1'b0;
    end else if (sum >= target) begin
      acc    <= sum - target;
      o_tick <= 1'b1;
    end else begin
      acc    <= sum;
      o_tick <= 1'b0;
    end
  end
endmodule // lin_frac_divider

// ==== core/lin_slave_header_divider.v ====
// LIN slave header detection, synch state, fractional divider, header length
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "lin_regs.vh"
module lin_slave_header_divider (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_receive_line,
  output wire       o_irq,
  output wire       o_tx_clk_on,
  output wire       o_rx_clk_on,
  output wire       o_baud_tick,
  output wire       o_synch_field_state,
  output wire       o_header_detected_flag,
  output wire       o_slave_mode
);
  localparam ST_IDLE    = 3'd0;
  localparam ST_BREAK   = 3'd1;
  localparam ST_SYNCH   = 3'd2;
  localparam ST_ID_WAIT = 3'd3;
  localparam ST_ID      = 3'd4;

  // Control register 3 fields, status error bit and clear arming
  reg        lin_enable;
  reg        slave_select_bit;
  reg        auto_synch_enable;
  reg        header_detect_method;
  reg        header_irq_enable;
  reg        header_detected_flag;
  reg        synch_field_state;
  reg        header_error;
  reg        status_touched;
  // Divider, legacy and header length storage
  reg  [7:0] divider_mantissa_reg;
  reg  [3:0] divider_fraction_reg;
  reg  [3:0] fraction_pending;
  reg  [7:0] legacy_baud;
  reg  [7:0] legacy_erpr;
  reg  [7:0] legacy_etpr;
  reg  [7:0] header_length_reg;
  // Receiver state
  reg  [2:0] state;
  reg        line_q;
  reg [10:0] hdr_ticks;
  reg [10:0] char_ticks;
  reg        char_run;
  reg  [2:0] fall_cnt;

  wire       slave_mode;
  wire       tick;
  wire       div_on;
  wire       rx_fall;
  wire       sel_status;
  wire       sel_baud;
  wire       sel_cr3;
  wire       sel_erpr;
  wire       sel_etpr;
  wire       cr3_read;
  wire       lsf_sw_clear;
  wire       break_seen;
  wire       timeout;
  wire       char_done;
  wire [10:0] ticks_rounded;
  wire [8:0] quarters;
  wire [8:0] code_full;
  wire [7:0] header_length_code;
  wire       header_done;
  wire       synch_done;

  function sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  assign slave_mode = lin_enable & slave_select_bit;
  assign sel_status = sel(i_addr, `ADDR_STATUS);
  assign sel_baud   = sel(i_addr, `ADDR_BAUD);
  assign sel_cr3    = sel(i_addr, `ADDR_CR3);
  assign sel_erpr   = sel(i_addr, `ADDR_ERPR);
  assign sel_etpr   = sel(i_addr, `ADDR_ETPR);
  assign cr3_read   = i_rd & sel_cr3;

  lin_frac_divider u_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_mantissa (slave_mode ? divider_mantissa_reg : `MANT_OFF),
    .i_fraction (divider_fraction_reg),
    .o_tick     (tick),
    .o_clk_on   (div_on)
  );

  assign o_tx_clk_on = div_on;
  assign o_rx_clk_on = div_on;
  assign o_baud_tick = tick;

  assign rx_fall    = line_q & ~i_receive_line;
  assign break_seen = tick & ~i_receive_line &
                      (hdr_ticks == `BREAK_TICKS - 11'd1);
  assign timeout    = (state != ST_IDLE) && (state != ST_BREAK) &&
                      (hdr_ticks >= `HEADER_MAX_TICKS);
  assign char_done  = char_run & tick &
                      (char_ticks == `CHAR_TICKS - 11'd1);

  // Round ticks to nearest quarter bit; carry lands in bits 10:2 naturally
  assign ticks_rounded      = hdr_ticks + `QUARTER_ROUND;
  assign quarters           = ticks_rounded[10:2];
  assign code_full          = `LHL_MAX_QUARTERS - quarters;
  assign header_length_code = code_full[7:0];

  assign header_done =
    slave_mode & ((state == ST_BREAK & ~header_detect_method &
                   i_receive_line) |
                  (state == ST_ID & header_detect_method & char_done));
  assign synch_done =
    slave_mode & (state == ST_SYNCH) & ~timeout &
    ((auto_synch_enable & rx_fall &
      (fall_cnt == `SYNCH_FALL_EDGES - 3'd1)) |
     (~auto_synch_enable & char_done));
  assign lsf_sw_clear = i_wr & sel_cr3 & synch_field_state &
                        ~i_wdata[`CR3_SYNCH_STATE];

  // Register writes of control, divider and legacy registers
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lin_enable           <= 1'b0;
      slave_select_bit     <= 1'b0;
      auto_synch_enable    <= 1'b0;
      header_detect_method <= 1'b0;
      header_irq_enable    <= 1'b0;
      divider_mantissa_reg <= `RESET_BYTE;
      divider_fraction_reg <= 4'h0;
      fraction_pending     <= 4'h0;
      legacy_baud          <= `RESET_BYTE;
      legacy_erpr          <= `RESET_BYTE;
      legacy_etpr          <= `RESET_BYTE;
    end else if (i_wr) begin
      if (sel_cr3) begin
        lin_enable           <= i_wdata[`CR3_LIN_ENABLE];
        slave_select_bit     <= i_wdata[`CR3_SLAVE_SELECT];
        auto_synch_enable    <= i_wdata[`CR3_AUTO_SYNCH];
        header_detect_method <= i_wdata[`CR3_DETECT_METHOD];
        header_irq_enable    <= i_wdata[`CR3_HDR_IRQ_EN];
      end else if (sel_baud & slave_mode) begin
        divider_mantissa_reg <= i_wdata;
        divider_fraction_reg <= fraction_pending;
      end else if (sel_baud) begin
        legacy_baud <= i_wdata;
      end else if (sel_etpr & slave_mode) begin
        fraction_pending <= i_wdata[`FRAC_MSB:0];
      end else if (sel_etpr) begin
        legacy_etpr <= i_wdata;
      end else if (sel_erpr & ~slave_mode) begin
        legacy_erpr <= i_wdata;
      end
    end
  end

  // Status access arms the flag clear, a control-3 read completes it
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_touched       <= 1'b0;
      header_detected_flag <= 1'b0;
      header_error         <= 1'b0;
    end else begin
      if ((i_rd | i_wr) & sel_status)
        status_touched <= 1'b1;
      else if (cr3_read)
        status_touched <= 1'b0;
      if (header_done)
        header_detected_flag <= 1'b1;
      else if (cr3_read & status_touched)
        header_detected_flag <= 1'b0;
      if (slave_mode & timeout)
        header_error <= 1'b1;
      else if (cr3_read & status_touched)
        header_error <= 1'b0;
    end
  end

  // Header receiver
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state             <= ST_IDLE;
      line_q            <= 1'b1;
      hdr_ticks         <= 11'd0;
      char_ticks        <= 11'd0;
      char_run          <= 1'b0;
      fall_cnt          <= 3'd0;
      synch_field_state <= 1'b0;
      header_length_reg <= `RESET_BYTE;
    end else begin
      line_q <= i_receive_line;
      if (!slave_mode) begin
        state    <= ST_IDLE;
        char_run <= 1'b0;
      end else begin
        if (tick && hdr_ticks != `HEADER_MAX_TICKS)
          hdr_ticks <= hdr_ticks + 11'd1;
        if (char_run & tick)
          char_ticks <= char_ticks + 11'd1;
        if (timeout) begin
          header_length_reg <= `LHL_TIMEOUT;
          synch_field_state <= 1'b0;
          char_run          <= 1'b0;
          state             <= ST_IDLE;
        end else if (lsf_sw_clear && !break_seen) begin
          synch_field_state <= 1'b0;
          char_run          <= 1'b0;
          state             <= ST_IDLE;
        end else begin
          case (state)
            ST_IDLE: begin
              if (rx_fall)
                hdr_ticks <= 11'd0;
              if (break_seen) begin
                synch_field_state <= 1'b1;
                header_length_reg <= `LHL_AFTER_BREAK;
                state             <= ST_BREAK;
              end
            end
            ST_BREAK: begin
              if (i_receive_line) begin
                fall_cnt <= 3'd0;
                state    <= ST_SYNCH;
                if (header_done)
                  header_length_reg <= header_length_code;
              end
            end
            ST_SYNCH: begin
              if (auto_synch_enable & rx_fall)
                fall_cnt <= fall_cnt + 3'd1;
              if (~auto_synch_enable & ~char_run & rx_fall) begin
                char_run   <= 1'b1;
                char_ticks <= 11'd0;
              end
              if (synch_done) begin
                synch_field_state <= 1'b0;
                char_run          <= 1'b0;
                state             <= ST_ID_WAIT;
              end
            end
            ST_ID_WAIT: begin
              if (rx_fall) begin
                char_run   <= 1'b1;
                char_ticks <= 11'd0;
                state      <= ST_ID;
              end
            end
            ST_ID: begin
              if (char_done) begin
                char_run <= 1'b0;
                state    <= ST_IDLE;
                if (header_done)
                  header_length_reg <= header_length_code;
              end
            end
            default: state <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Read data stand for one cycle after the read strobe
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `RESET_BYTE;
    end else if (!i_rd) begin
      o_rdata <= `RESET_BYTE;
    end else if (sel_status) begin
      o_rdata <= {4'h0, header_error, 3'h0};
    end else if (sel_cr3) begin
      o_rdata <= {1'b0, lin_enable, slave_select_bit, auto_synch_enable,
                  header_detect_method, header_irq_enable,
                  header_detected_flag, synch_field_state};
    end else if (sel_baud) begin
      o_rdata <= slave_mode ? divider_mantissa_reg : legacy_baud;
    end else if (sel_etpr) begin
      o_rdata <= slave_mode ? {4'h0, divider_fraction_reg}
                            : legacy_etpr;
    end else if (sel_erpr) begin
      if (!slave_mode)
        o_rdata <= legacy_erpr;
      else if (auto_synch_enable | header_detect_method)
        o_rdata <= header_length_reg;
      else
        o_rdata <= `RESET_BYTE;
    end else begin
      o_rdata <= `RESET_BYTE;
    end
  end

  assign o_irq = slave_mode & header_irq_enable & header_detected_flag;
  assign o_synch_field_state    = synch_field_state;
  assign o_header_detected_flag = header_detected_flag;
  assign o_slave_mode           = slave_mode;
endmodule // lin_slave_header_divider

// ==== dv/lin_master_node.sv ====
// LIN master node model driving headers on the receive line
`timescale 1ns/1ns
module lin_master_node #(
  parameter BIT_CLKS = 16
) (
  input  wire i_clk,
  output reg  o_line
);
  // Recessive idle level, as the bus pull-up leaves it
  initial o_line = 1'b1;

  task automatic hold(input integer n, input v);
    o_line <= v;
    repeat (n) @(posedge i_clk);
  endtask

  // Two stop bits give the slave a gap between characters
  task automatic chr(input [7:0] b);
    integer i;
    hold(BIT_CLKS, 1'b0);
    for (i = 0; i < 8; i++) hold(BIT_CLKS, b[i]);
    hold(2 * BIT_CLKS, 1'b1);
  endtask

  task automatic send_header(input full, input [7:0] id);
    hold(13 * BIT_CLKS, 1'b0);
    hold(BIT_CLKS, 1'b1);
    if (full) begin
      chr(8'h55);
      chr(id);
    end
  endtask
endmodule // lin_master_node

// ==== dv/lin_slave_header_divider_asserts.sv ====
// Assertion checker for the LIN slave header and divider block
`timescale 1ns/1ns
module lin_slave_header_divider_asserts (
  input wire       i_clk,
  input wire       i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       o_irq,
  input wire       o_rx_clk_on,
  input wire       o_baud_tick,
  input wire       o_synch_field_state,
  input wire       o_header_detected_flag,
  input wire       o_slave_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_irq;
    o_irq |-> o_slave_mode && o_header_detected_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");

  property p_tick;
    !o_rx_clk_on [*3] |-> !o_baud_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick while off");

  property p_mode;
    i_wr && i_addr == 8'h45 |=>
      o_slave_mode == ($past(i_wdata[6]) & $past(i_wdata[5]));
  endproperty
  a_mode: assert property (p_mode) else $error("slave mode wrong");

  property p_cr3;
    i_rd && i_addr == 8'h45 |=> o_rdata[1] == $past(o_header_detected_flag)
      && o_rdata[0] == $past(o_synch_field_state);
  endproperty
  a_cr3: assert property (p_cr3) else $error("state bits read wrong");

  property p_hold;
    o_header_detected_flag && !i_wr && !(i_rd && i_addr == 8'h45)
      |=> o_header_detected_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");

  property p_abort;
    o_synch_field_state && i_wr && i_addr == 8'h45 && !i_wdata[0]
      |=> !o_synch_field_state;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_frac;
    i_rd && i_addr == 8'h47 && o_slave_mode |=> o_rdata[7:4] == 4'h0;
  endproperty
  a_frac: assert property (p_frac) else $error("reserved bits set");

  property p_rise;
    $rose(o_synch_field_state) || $rose(o_header_detected_flag)
      |-> $past(o_slave_mode);
  endproperty
  a_rise: assert property (p_rise) else $error("update off slave");
endmodule // lin_slave_header_divider_asserts

bind lin_slave_header_divider lin_slave_header_divider_asserts chk_u (
  .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
  .o_rx_clk_on, .o_baud_tick, .o_synch_field_state, .o_header_detected_flag,
  .o_slave_mode
);

// ==== dv/test_lin_slave_header_divider.sv ====
// Self-checking testbench of the LIN slave header and divider block
`timescale 1ns/1ns
module test_lin_slave_header_divider;
  reg        i_clk = 1'b0;
  reg        i_rst_n = 1'b0;
  reg  [7:0] i_addr = 8'h00;
  reg  [7:0] i_wdata = 8'h00;
  reg        i_wr = 1'b0;
  reg        i_rd = 1'b0;
  wire [7:0] o_rdata;
  wire       rx_line;
  wire       o_irq, o_tx_clk_on, o_rx_clk_on, o_baud_tick;
  wire       o_synch_field_state, o_header_detected_flag, o_slave_mode;
  wire [1:0] st = {o_header_detected_flag, o_synch_field_state};
  integer    failures = 0;
  integer    checks_done = 0;
  integer    ticks = 0;

  lin_slave_header_divider dut_u (
    .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_receive_line(rx_line), .o_irq, .o_tx_clk_on, .o_rx_clk_on,
    .o_baud_tick, .o_synch_field_state, .o_header_detected_flag,
    .o_slave_mode
  );
  lin_master_node #(.BIT_CLKS(16)) master_u (.i_clk(i_clk), .o_line(rx_line));

  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_baud_tick === 1'b1) ticks <= ticks + 1;

  task automatic chk(input string what, input [7:0] seen, input [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %0s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input [7:0] a, input [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), o_rdata, exp);
  endtask

  task automatic wt(input integer k, input v, input integer lim);
    integer n;
    for (n = 0; n < lim && st[k] !== v; n++) @(posedge i_clk) #1;
    chk($sformatf("state bit %0d", k), st[k], v);
  endtask

  task automatic t_reset;
    rdc(8'h42, 8'h00);
    rdc(8'h45, 8'h00);
    rdc(8'h46, 8'h00);
    rdc(8'h47, 8'h00);
    rdc(8'h41, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_divider;
    integer base;
    integer n;
    wr(8'h45, 8'h60);
    wr(8'h47, 8'hfc);
    rdc(8'h47, 8'h00);
    wr(8'h42, 8'h02);
    rdc(8'h47, 8'h0c);
    rdc(8'h42, 8'h02);
    base = ticks;
    repeat (440) @(posedge i_clk);
    n = ticks - base;
    chk("tick count", n > 158 && n < 162, 8'h01);
    wr(8'h42, 8'h00);
    chk("clock on", o_tx_clk_on, 8'h00);
    // Let the last tick of the old divider be counted first
    repeat (2) @(negedge i_clk);
    base = ticks;
    repeat (50) @(posedge i_clk);
    chk("tick count", ticks == base, 8'h01);
    wr(8'h47, 8'h00);
    wr(8'h42, 8'h01);
    chk("clock on", o_rx_clk_on, 8'h01);
    $display("test divider done");
  endtask

  task automatic t_method0;
    wr(8'h45, 8'h74);
    fork
      master_u.send_header(1'b1, 8'h3c);
      begin
        wt(0, 1'b1, 300);
        rdc(8'h46, 8'hff);
        wt(1, 1'b1, 100);
        rdc(8'h46, 8'hb0);
        chk("irq", o_irq, 8'h01);
        wt(0, 1'b0, 300);
      end
    join
    rdc(8'h45, 8'h76);
    rdc(8'h40, 8'h00);
    rdc(8'h45, 8'h76);
    chk("flag", o_header_detected_flag, 8'h00);
    $display("test method 0 done");
  endtask

  task automatic t_method1;
    wr(8'h45, 8'h68);
    fork
      master_u.send_header(1'b1, 8'h3c);
      begin
        wt(0, 1'b1, 300);
        wt(0, 1'b0, 600);
        chk("flag", o_header_detected_flag, 8'h00);
      end
    join
    wt(1, 1'b1, 40);
    rdc(8'h46, 8'h58);
    rdc(8'h40, 8'h00);
    rdc(8'h45, 8'h6a);
    // Length hidden without auto synch or method 1, kept underneath
    wr(8'h45, 8'h60);
    rdc(8'h46, 8'h00);
    wr(8'h45, 8'h68);
    rdc(8'h46, 8'h58);
    $display("test method 1 done");
  endtask

  task automatic t_fault;
    wr(8'h45, 8'h70);
    fork
      master_u.send_header(1'b0, 8'h00);
      begin
        wt(0, 1'b1, 300);
        repeat (40) @(posedge i_clk);
        wr(8'h45, 8'h70);
        chk("synch", o_synch_field_state, 8'h00);
      end
    join
    fork
      master_u.send_header(1'b0, 8'h00);
      wt(0, 1'b1, 300);
    join
    wt(0, 1'b0, 1000);
    rdc(8'h46, 8'h00);
    rdc(8'h40, 8'h08);
    // Break alone is a header with method 0, so the flag stands
    rdc(8'h45, 8'h72);
    rdc(8'h40, 8'h00);
    $display("test fault done");
  endtask

  task automatic t_modes;
    wr(8'h45, 8'h48);
    master_u.send_header(1'b0, 8'h00);
    chk("state", st, 8'h00);
    chk("mode", o_slave_mode, 8'h00);
    wr(8'h45, 8'h60);
    rdc(8'h46, 8'h00);
    $display("test modes done");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_divider;
    t_method0;
    t_method1;
    t_fault;
    t_modes;
    finish_test;
  end

  initial begin
    #(50 * 20000);
    failures++;
    finish_test;
  end
endmodule // test_lin_slave_header_divider
